// File: hw/ardc_cmd.sv
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ardc_cmd
  import ardc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Slave-DMA channel
  output logic             dmarq,
  input  wire logic        dmack,
  input  wire logic        dmaCrcErr,
  output logic      [15:0] dmaData,
  output logic             intrq,
  // Media channel
  output logic             mediaReq,
  output logic      [27:0] mediaAddr,
  output logic             mediaLbaMode,
  input  wire logic        mediaValid,
  input  wire logic [15:0] mediaData,
  input  wire logic        mediaUnc,
  input  wire logic        mediaIdnf
);

  typedef struct packed {
    ardc_state_t       state;
    logic [7:0]        feature;
    logic [7:0]        count;
    logic [7:0]        secnum;
    logic [7:0]        cyllo;
    logic [7:0]        cylhi;
    logic [7:0]        devhead;
    logic [7:0]        errFlags;
    logic              busy_flag;
    logic              drq;
    logic              errSt;
    logic              intrq;
    logic [8:0]        remain;
    logic [7:0]        wordIdx;
    logic [255:0][15:0] sbuf;
    logic              dmarq;
    logic [15:0]       dmaData;
    logic              mediaReq;
    logic [27:0]       mediaAddr;
    logic              mediaLbaMode;
    logic              pend;
    logic              pWr;
    logic              pMap;
    logic [4:0]        pOfs;
    logic              hreadyOut;
    logic [31:0]       hrdata;
  } ardc_st_t;

  ardc_st_t s;
  ardc_st_t next_s;
  logic     cmdWr;
  logic     dhOk;

  // ----------------------------------------
  // Address stepping
  // ----------------------------------------
  // CHS wraps sector to 1, then head, then cylinder
  function automatic logic [27:0] nextAddr(input logic [27:0] a,
                                           input logic        lba);
    logic [27:0] r;
    r = a;
    if (lba) begin
      r = a + 28'h0000001;
    end else if (a[7:0] < SPT) begin
      r[7:0] = a[7:0] + 8'h01;
    end else begin
      r[7:0] = 8'h01;
      if (a[27:24] < HEAD_LAST) begin
        r[27:24] = a[27:24] + 4'h1;
      end else begin
        r[27:24] = 4'h0;
        r[23:8]  = a[23:8] + 16'h0001;
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Command acceptance
  // ----------------------------------------
  // Writes while busy or mid-sector are dropped
  assign cmdWr = s.pend && s.pWr && s.pMap && (s.pOfs == OFS_STATCMD)
                 && !s.busy_flag && !s.drq
                 && (s.devhead[DH_DEV] == UNIT_SEL);
  assign dhOk  = s.devhead[DH_ONE7] && s.devhead[DH_ONE5];

  always_comb begin
    logic [7:0]  stat;
    logic [7:0]  op;
    logic [7:0]  errBits;
    logic        done;
    logic [27:0] na;
    next_s  = s;
    stat    = '0;
    op      = hwdata[7:0];
    errBits = '0;
    done    = 1'b0;
    na      = '0;
    next_s.mediaReq = 1'b0;

    stat[ST_BSY] = s.busy_flag;
    stat[ST_RDY] = 1'b1;
    stat[ST_DF]  = 1'b0;
    stat[ST_DSC] = 1'b1;
    stat[ST_DRQ] = s.drq;
    stat[ST_ERR] = s.errSt;

    // ----------------------------------------
    // Bus slave: one wait state per transfer
    // ----------------------------------------
    if (hready && s.hreadyOut && hsel && htrans[1]) begin
      next_s.pend      = 1'b1;
      next_s.pWr       = hwrite;
      next_s.pOfs      = haddr[4:0];
      next_s.pMap      = (haddr[31:5] == 27'h0000000);
      next_s.hreadyOut = 1'b0;
    end

    if (s.pend) begin
      next_s.pend      = 1'b0;
      next_s.hreadyOut = 1'b1;
      next_s.hrdata    = '0;
      if (!s.pWr && s.pMap) begin
        unique case (s.pOfs)
          OFS_DATA: begin
            if (s.state == S_PIO) begin
              next_s.hrdata  = {16'h0000, s.sbuf[s.wordIdx]};
              next_s.wordIdx = s.wordIdx + 8'h01;
              if (s.wordIdx == LAST_WORD) begin
                next_s.drq   = 1'b0;
                next_s.state = S_IDLE;
              end
            end
          end
          OFS_ERRFEAT: next_s.hrdata = {24'h000000, s.errFlags};
          OFS_COUNT:   next_s.hrdata = {24'h000000, s.count};
          OFS_SECNUM:  next_s.hrdata = {24'h000000, s.secnum};
          OFS_CYLLO:   next_s.hrdata = {24'h000000, s.cyllo};
          OFS_CYLHI:   next_s.hrdata = {24'h000000, s.cylhi};
          OFS_DEVHEAD: next_s.hrdata = {24'h000000, s.devhead};
          OFS_STATCMD: begin
            next_s.hrdata = {24'h000000, stat};
            next_s.intrq  = 1'b0;
          end
          default: next_s.hrdata = '0;
        endcase
      end else if (s.pWr && s.pMap && !s.busy_flag && !s.drq) begin
        unique case (s.pOfs)
          OFS_ERRFEAT: next_s.feature = hwdata[7:0];
          OFS_COUNT:   next_s.count   = hwdata[7:0];
          OFS_SECNUM:  next_s.secnum  = hwdata[7:0];
          OFS_CYLLO:   next_s.cyllo   = hwdata[7:0];
          OFS_CYLHI:   next_s.cylhi   = hwdata[7:0];
          OFS_DEVHEAD: next_s.devhead = hwdata[7:0];
          default: ;
        endcase
      end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    if (cmdWr) begin
      next_s.intrq    = 1'b0;
      next_s.errFlags = '0;
      next_s.errSt    = 1'b0;
      if (dhOk && op == OP_READ_BUF) begin
        // Sole buffer region, so last written data is what returns
        next_s.state   = S_PIO;
        next_s.drq     = 1'b1;
        next_s.wordIdx = 8'h00;
        next_s.intrq   = 1'b1;
      end else if (dhOk && op[7:1] == OP_READ_DMA) begin
        next_s.state        = S_MEDIA;
        next_s.busy_flag          = 1'b1;
        next_s.wordIdx      = 8'h00;
        next_s.remain       = (s.count == 8'h00) ? MAX_SECTORS
                              : {1'b0, s.count};
        next_s.mediaReq     = 1'b1;
        next_s.mediaAddr    = {s.devhead[3:0], s.cylhi,
                               s.cyllo, s.secnum};
        next_s.mediaLbaMode = s.devhead[DH_LBA];
      end else begin
        next_s.errFlags[ERR_ABT] = 1'b1;
        next_s.errSt             = 1'b1;
        next_s.intrq             = 1'b1;
      end
    end

    // ----------------------------------------
    // Sector engine
    // ----------------------------------------
    unique case (s.state)
      S_IDLE, S_PIO: ;
      S_MEDIA: begin
        if (mediaUnc || mediaIdnf) begin
          done             = 1'b1;
          errBits[ERR_UNC] = mediaUnc;
          errBits[ERR_IDN] = mediaIdnf;
        end else if (mediaValid) begin
          next_s.sbuf[s.wordIdx] = mediaData;
          next_s.wordIdx         = s.wordIdx + 8'h01;
          if (s.wordIdx == LAST_WORD) begin
            next_s.state   = S_XFER;
            next_s.dmarq   = 1'b1;
            next_s.dmaData = s.sbuf[0];
          end
        end
      end
      S_XFER: begin
        // CRC trouble ends the command at once, data already sent
        if (dmaCrcErr) begin
          done             = 1'b1;
          errBits[ERR_CRC] = 1'b1;
          errBits[ERR_ABT] = 1'b1;
        end else if (dmack) begin
          next_s.wordIdx = s.wordIdx + 8'h01;
          next_s.dmaData = s.sbuf[s.wordIdx + 8'h01];
          if (s.wordIdx == LAST_WORD) begin
            next_s.dmarq  = 1'b0;
            next_s.remain = s.remain - 9'h001;
            next_s.count  = next_s.remain[7:0];
            if (s.remain == 9'h001) begin
              done = 1'b1;
            end else begin
              na = nextAddr(s.mediaAddr, s.mediaLbaMode);
              next_s.devhead[3:0] = na[27:24];
              next_s.cylhi        = na[23:16];
              next_s.cyllo        = na[15:8];
              next_s.secnum       = na[7:0];
              next_s.mediaAddr    = na;
              next_s.mediaReq     = 1'b1;
              next_s.state        = S_MEDIA;
            end
          end
        end
      end
    endcase

    // Completion event wins over a same-cycle status read
    if (done) begin
      next_s.state    = S_IDLE;
      next_s.busy_flag      = 1'b0;
      next_s.dmarq    = 1'b0;
      next_s.errFlags = errBits;
      next_s.errSt    = |errBits;
      next_s.intrq    = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s           <= '0;
      s.state     <= S_IDLE;
      s.count     <= ONE_RST;
      s.secnum    <= ONE_RST;
      s.devhead   <= DEVHEAD_RST;
      s.hreadyOut <= HREADY_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hrdata       = s.hrdata;
  assign hreadyout    = s.hreadyOut;
  // Never an error response: unmapped space reads zero
  assign hresp        = 1'b0;
  assign dmarq        = s.dmarq;
  assign dmaData      = s.dmaData;
  assign intrq        = s.intrq;
  assign mediaReq     = s.mediaReq;
  assign mediaAddr    = s.mediaAddr;
  assign mediaLbaMode = s.mediaLbaMode;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  pio_start_a: assert property (
    cmdWr && dhOk && hwdata[7:0] == OP_READ_BUF
    |=> s.drq && s.state == S_PIO && s.wordIdx == 8'h00)
    else $error("buffer read did not start");

  pio_end_a: assert property (
    s.pend && !s.pWr && s.pMap && s.pOfs == OFS_DATA
    && s.state == S_PIO && s.wordIdx == LAST_WORD
    |=> !s.drq && s.state == S_IDLE)
    else $error("buffer read length wrong");

  dma_start_a: assert property (
    cmdWr && dhOk && hwdata[7:1] == OP_READ_DMA
    |=> s.busy_flag && s.mediaReq && s.state == S_MEDIA)
    else $error("dma read did not start");

  zero_count_a: assert property (
    cmdWr && dhOk && hwdata[7:1] == OP_READ_DMA && s.count == 8'h00
    |=> s.remain == MAX_SECTORS)
    else $error("zero count not 256");

  dmarq_xfer_a: assert property (
    s.dmarq |-> s.state == S_XFER && s.busy_flag)
    else $error("dmarq outside transfer");

  intr_done_a: assert property (
    $rose(s.intrq) |-> !s.busy_flag && !s.dmarq)
    else $error("interrupt while busy");

  unc_stop_a: assert property (
    s.state == S_MEDIA && mediaUnc
    |=> !s.busy_flag && !s.dmarq && s.errFlags[ERR_UNC] && s.errSt
    ##1 !s.dmarq)
    else $error("uncorrectable did not stop");

  done_count_a: assert property (
    $fell(s.busy_flag) && !s.errSt |-> s.count == 8'h00)
    else $error("count not zero at end");

  media_addr_a: assert property (
    s.mediaReq |-> s.mediaAddr == {s.devhead[3:0], s.cylhi,
                                   s.cyllo, s.secnum})
    else $error("address registers off");

  bus_wait_a: assert property (
    hready && s.hreadyOut && hsel && htrans[1]
    |=> !s.hreadyOut ##1 s.hreadyOut)
    else $error("bus answer timing");

  drq_pio_a: assert property (
    s.drq |-> s.state == S_PIO && !s.busy_flag)
    else $error("data request outside buffer read");

  abort_cmd_a: assert property (
    cmdWr && !dhOk
    |=> s.errFlags[ERR_ABT] && s.errSt && s.intrq && s.state == S_IDLE)
    else $error("bad device head not aborted");

  lba_mode_a: assert property (
    cmdWr && dhOk && hwdata[7:1] == OP_READ_DMA
    |=> s.mediaLbaMode == $past(s.devhead[DH_LBA]))
    else $error("addressing mode not taken");

  crc_stop_a: assert property (
    s.state == S_XFER && dmaCrcErr
    |=> !s.busy_flag && !s.dmarq && s.errFlags[ERR_CRC] && s.errFlags[ERR_ABT])
    else $error("crc error did not stop");

  idnf_stop_a: assert property (
    s.state == S_MEDIA && mediaIdnf
    |=> !s.busy_flag && s.errFlags[ERR_IDN] && s.errSt && s.intrq)
    else $error("missing sector did not stop");

  count_step_a: assert property (
    s.state == S_XFER && dmack && !dmaCrcErr && s.wordIdx == LAST_WORD
    |=> s.remain == $past(s.remain) - 9'h001 && s.count == s.remain[7:0])
    else $error("sector count not stepped");

endmodule

// File: hw/ardc_pkg.sv
// Notes on behaviour
// - Opcode E4h selects buffer read; device/head bits 7, 5 set; D picks unit.
// - Buffer read returns exactly one sector from the sector buffer.
// - Buffer read words leave through the data register, 16 bits each.
// - Buffer read uses the buffer region last filled by a buffer write; here it returns the sector last filled by a DMA read.
// - DMA read opcodes are C8h and C9h; bit 0 is the retry bit.
// - DMA read fetches sectors from media, then sends them to host.
// - DMA read data moves as one 16-bit word per transfer.
// - Each DMA word is qualified by dmarq; host channel moves it.
// - One interrupt per DMA read, after transfer ends and status valid.
// - Uncorrectable sector stops DMA read there; no further sectors sent.
// - Sector count gives consecutive sectors; zero means 256.
// - Sector number is start sector, or LBA bits 0-7 in LBA mode.
// - Cylinder low/high are start cylinder, or LBA bits 8-23.
// - Device/head low nibble is start head, or LBA bits 24-27.
// - Retry bit is ignored; both DMA opcodes act the same.
// - Final sector count is sectors not transferred; zero unless error.
// - Final address registers show the last transferred sector, or the failing sector when an error ends the read.
package ardc_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_DATA    = 5'h00;
  localparam logic [4:0] OFS_ERRFEAT = 5'h04;
  localparam logic [4:0] OFS_COUNT   = 5'h08;
  localparam logic [4:0] OFS_SECNUM  = 5'h0C;
  localparam logic [4:0] OFS_CYLLO   = 5'h10;
  localparam logic [4:0] OFS_CYLHI   = 5'h14;
  localparam logic [4:0] OFS_DEVHEAD = 5'h18;
  localparam logic [4:0] OFS_STATCMD = 5'h1C;

  // ----------------------------------------
  // Opcodes and field positions
  // ----------------------------------------
  localparam logic [7:0] OP_READ_BUF = 8'hE4;
  localparam logic [6:0] OP_READ_DMA = 7'h64;
  localparam int DH_ONE7 = 7;
  localparam int DH_LBA  = 6;
  localparam int DH_ONE5 = 5;
  localparam int DH_DEV  = 4;
  localparam int ERR_CRC = 7;
  localparam int ERR_UNC = 6;
  localparam int ERR_IDN = 4;
  localparam int ERR_ABT = 2;
  localparam int ST_BSY  = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_DF   = 5;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;

  // ----------------------------------------
  // Counts, geometry, reset values
  // ----------------------------------------
  localparam logic [7:0] LAST_WORD   = 8'hFF;
  localparam logic [8:0] MAX_SECTORS = 9'h100;
  localparam logic [7:0] SPT         = 8'h3F;
  localparam logic [3:0] HEAD_LAST   = 4'hF;
  localparam logic       UNIT_SEL    = 1'h0;
  localparam logic [7:0] DEVHEAD_RST = 8'hA0;
  localparam logic [7:0] ONE_RST     = 8'h01;
  localparam logic       HREADY_RST  = 1'h1;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_PIO   = 4'h2,
    S_MEDIA = 4'h4,
    S_XFER  = 4'h8
  } ardc_state_t;

endpackage

// File: verif/ardc_host_model.sv
`timescale 1ns/1ps
module ardc_host_model (
  // Clock, reset, bench knobs
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        stall,
  input  wire logic        gap,
  input  wire logic [7:0]  uncSec,
  input  wire logic        useIdnf,
  // Slave-DMA channel
  input  wire logic        dmarq,
  output logic             dmack,
  // Media channel
  input  wire logic        mediaReq,
  input  wire logic [27:0] mediaAddr,
  output logic             mediaValid,
  output logic      [15:0] mediaData,
  output logic             mediaUnc,
  output logic             mediaIdnf
);
  logic       active;
  logic [8:0] idx;
  logic [7:0] tag;
  // Channel is always armed; it stalls at random
  always @(posedge clk) begin
    dmack <= dmarq & ~stall & ~srst;
  end
  // One sector of 256 words per request, word = {addr low, index}
  always @(posedge clk) begin
    mediaUnc <= 1'b0;
    mediaIdnf <= 1'b0;
    mediaValid <= 1'b0;
    mediaData <= ~mediaData;
    if (srst) begin
      active <= 1'b0;
      mediaData <= 16'h0000;
    end else if (mediaReq) begin
      active <= 1'b1;
      idx <= 9'h0;
      tag <= mediaAddr[7:0];
    end else if (active && tag == uncSec && idx == 9'h8) begin
      mediaUnc <= ~useIdnf;
      mediaIdnf <= useIdnf;
      active <= 1'b0;
    end else if (active && !gap) begin
      mediaValid <= 1'b1;
      mediaData <= {tag, idx[7:0]};
      idx <= idx + 9'h1;
      if (idx == 9'hFF) active <= 1'b0;
    end
  end
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb
  import ardc_pkg::*;
;
  logic        clk, srst, hsel, hwrite, hresp, hreadyout, expLba;
  logic        dmarq, dmack, intrq, dmaCrcErr, stall, gap, useIdnf;
  logic        mediaReq, mediaLbaMode, mediaValid, mediaUnc, mediaIdnf;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  uncSec;
  logic [15:0] dmaData, mediaData;
  logic [27:0] mediaAddr;
  logic [31:0] haddr, hwdata, hrdata, rnd, rdv;
  logic [15:0] exq[$];
  logic [27:0] aq[$];
  int          err_total, samples_checked, cyc;
  wire         hready = hreadyout;

  ardc_cmd DUT (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .dmarq(dmarq), .dmack(dmack), .dmaCrcErr(dmaCrcErr),
    .dmaData(dmaData), .intrq(intrq), .mediaReq(mediaReq),
    .mediaAddr(mediaAddr), .mediaLbaMode(mediaLbaMode),
    .mediaValid(mediaValid), .mediaData(mediaData),
    .mediaUnc(mediaUnc), .mediaIdnf(mediaIdnf));
  ardc_host_model partner (.clk(clk), .srst(srst), .stall(stall),
    .gap(gap), .uncSec(uncSec), .useIdnf(useIdnf), .dmarq(dmarq),
    .dmack(dmack),
    .mediaReq(mediaReq), .mediaAddr(mediaAddr), .mediaValid(mediaValid),
    .mediaData(mediaData), .mediaUnc(mediaUnc), .mediaIdnf(mediaIdnf));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Address phase held until hready, then data phase until hready
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    ahb(1'b1, {27'h0, a}, d);
  endtask
  task automatic rd(input logic [4:0] a);
    ahb(1'b0, {27'h0, a}, 32'h0);
  endtask
  task automatic setup(input logic [7:0] c, s, l, h, d);
    wr(OFS_COUNT, {24'h0, c});
    wr(OFS_SECNUM, {24'h0, s});
    wr(OFS_CYLLO, {24'h0, l});
    wr(OFS_CYLHI, {24'h0, h});
    wr(OFS_DEVHEAD, {24'h0, d});
  endtask
  // Reference: addresses requested and words expected on the channel
  task automatic plan(input logic [27:0] a0, input int nReq, nData);
    for (int s = 0; s < nReq; s++) aq.push_back(a0 + 28'(s));
    for (int s = 0; s < nData; s++)
      for (int i = 0; i < 256; i++)
        exq.push_back({a0[7:0] + 8'(s), 8'(i)});
  endtask
  task automatic waitirq();
    int n;
    n = 0;
    while (intrq !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, intrq}, 32'h1);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    rnd <= xs(rnd);
    stall <= rnd[0];
    gap <= rnd[1] & rnd[2];
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end
  always @(posedge clk) begin
    if (dmarq === 1'b1 && dmack === 1'b1) begin
      if (exq.size() == 0) chk(32'h1, 32'h0);
      else chk({16'h0, dmaData}, {16'h0, exq.pop_front()});
    end
    if (mediaReq === 1'b1) begin
      chk({31'h0, mediaLbaMode}, {31'h0, expLba});
      if (aq.size() == 0) chk(32'h1, 32'h0);
      else chk({4'h0, mediaAddr}, {4'h0, aq.pop_front()});
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {srst, hsel, hwrite, dmaCrcErr, stall, gap, expLba} = 7'h40;
    {htrans, hsize, haddr, hwdata} = {2'h0, 3'h2, 64'h0};
    {uncSec, rnd, err_total, samples_checked, cyc} = {8'hFF, 32'h1662, 96'h0};
    useIdnf = 1'b0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(OFS_DEVHEAD);
    chk(rdv, 32'hA0);
    rd(OFS_STATCMD);
    chk(rdv, 32'h50);
    ahb(1'b0, 32'h100, 32'h0);
    chk(rdv, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      wr(OFS_DEVHEAD, k ? 32'h00 : 32'hA0);
      wr(OFS_STATCMD, k ? 32'hE4 : 32'h00);
      waitirq();
      rd(OFS_ERRFEAT);
      chk(rdv, 32'h04);
      rd(OFS_STATCMD);
      chk(rdv, 32'h51);
      chk({31'h0, intrq}, 32'h0);
    end
    $display("test abort done");
    expLba = 1'b1;
    plan(28'h5123410, 2, 2);
    setup(8'h02, 8'h10, 8'h34, 8'h12, 8'hE5);
    wr(OFS_STATCMD, 32'hC8);
    waitirq();
    chk(exq.size(), 32'h0);
    rd(OFS_COUNT);
    chk(rdv, 32'h0);
    rd(OFS_SECNUM);
    chk(rdv, 32'h11);
    rd(OFS_CYLLO);
    chk(rdv, 32'h34);
    rd(OFS_DEVHEAD);
    chk({28'h0, rdv[3:0]}, 32'h5);
    rd(OFS_ERRFEAT);
    chk(rdv, 32'h0);
    rd(OFS_STATCMD);
    chk(rdv, 32'h50);
    $display("test lba dma done");
    wr(OFS_STATCMD, 32'hE4);
    repeat (2) @(posedge clk);
    chk({31'h0, intrq}, 32'h1);
    rd(OFS_STATCMD);
    chk(rdv, 32'h58);
    for (int i = 0; i < 256; i++) begin
      rd(OFS_DATA);
      chk(rdv, {16'h0, 8'h11, 8'(i)});
    end
    rd(OFS_STATCMD);
    chk(rdv, 32'h50);
    $display("test buffer read done");
    expLba = 1'b0;
    uncSec <= 8'h06;
    plan(28'h3007805, 2, 1);
    setup(8'h03, 8'h05, 8'h78, 8'h00, 8'hA3);
    wr(OFS_STATCMD, 32'hC9);
    waitirq();
    chk({31'h0, dmarq}, 32'h0);
    chk(exq.size() + aq.size(), 32'h0);
    rd(OFS_COUNT);
    chk(rdv, 32'h2);
    rd(OFS_SECNUM);
    chk(rdv, 32'h06);
    rd(OFS_ERRFEAT);
    chk(rdv, 32'h40);
    rd(OFS_STATCMD);
    chk(rdv, 32'h51);
    $display("test failing sector done");
    expLba = 1'b1;
    plan(28'h0000020, 1, 1);
    setup(8'h01, 8'h20, 8'h00, 8'h00, 8'hE0);
    wr(OFS_STATCMD, 32'hC8);
    while (dmarq !== 1'b1) @(posedge clk);
    repeat (20) @(posedge clk);
    dmaCrcErr <= 1'b1;
    @(posedge clk);
    dmaCrcErr <= 1'b0;
    waitirq();
    chk({31'h0, dmarq}, 32'h0);
    exq.delete();
    rd(OFS_COUNT);
    chk(rdv, 32'h1);
    rd(OFS_ERRFEAT);
    chk(rdv, 32'h84);
    rd(OFS_STATCMD);
    chk(rdv, 32'h51);
    $display("test crc stop done");
    uncSec <= 8'h20;
    useIdnf <= 1'b1;
    plan(28'h0000020, 1, 0);
    setup(8'h00, 8'h20, 8'h00, 8'h00, 8'hE0);
    wr(OFS_STATCMD, 32'hC8);
    waitirq();
    chk(aq.size(), 32'h0);
    rd(OFS_COUNT);
    chk(rdv, 32'h0);
    rd(OFS_ERRFEAT);
    chk(rdv, 32'h10);
    rd(OFS_STATCMD);
    chk(rdv, 32'h51);
    $display("test missing sector done");
    summarize();
  end
endmodule
